// ### verilog/vst_pkg.sv
// Package of timing constants and encodings for the valley switching timing core
package vst_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;

  // Times in their own units, as printed or as plain defaults
  localparam int unsigned UPDATE_PERIOD_MS     = 48;
  localparam int unsigned SOFT_SUPPRESS_MS     = 3;
  localparam int unsigned SOFT_SUPPRESS_US     = 25;
  localparam int unsigned LINE_BLANK_US        = 500;
  localparam int unsigned SHORT_SUPPRESS_NS    = 2500;
  localparam int unsigned LONG_SUPPRESS_NS     = 25000;
  localparam int unsigned MAX_OFF_US           = 50;
  localparam int unsigned MAX_ON_US            = 30;
  localparam int unsigned LEAD_BLANK_NS        = 220;
  localparam int unsigned SHORT_SAMPLE_NS      = 400;

  // Cycle counts: least times round up, longest times round down
  localparam int unsigned UPDATE_CYC   = UPDATE_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFT_CYC     = SOFT_SUPPRESS_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFT_RS_CYC  = SOFT_SUPPRESS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LINE_BLK_CYC = LINE_BLANK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHORT_RS_CYC = (SHORT_SUPPRESS_NS * 50 + 999) / 1000;
  localparam int unsigned LONG_RS_CYC  = (LONG_SUPPRESS_NS * 50 + 999) / 1000;
  localparam int unsigned MAX_OFF_CYC  = MAX_OFF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MAX_ON_CYC   = MAX_ON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LEB_CYC      = (LEAD_BLANK_NS * 50 + 999) / 1000;
  localparam int unsigned SAMPLE_CYC   = (SHORT_SAMPLE_NS * 50 + 999) / 1000;

  localparam int unsigned TMR_W = 24;

  // Counter range limits
  localparam logic [3:0] LOW_MIN  = 4'h1;
  localparam logic [3:0] LOW_MAX  = 4'h8;
  localparam logic [3:0] HIGH_MIN = 4'h3;
  localparam logic [3:0] HIGH_MAX = 4'hA;

  localparam logic [1:0] SHORT_PULSE_LIMIT = 2'h3;

  typedef enum logic [2:0] {
    VST_OFF_SUPPRESS = 3'b001,
    VST_OFF_WAIT     = 3'b010,
    VST_ON           = 3'b100
  } vst_gate_e;

endpackage : vst_pkg

// ### verilog/vst_sync.sv
// Two flip-flop synchroniser for a group of comparator flags
`timescale 1ns/1ns
module vst_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : vst_sync

// ### verilog/vst_core.sv
// Valley switching timing core: line range, up/down counter, valley gate timing
`timescale 1ns/1ns
module vst_core #(
  parameter int unsigned UPDATE_CYC = vst_pkg::UPDATE_CYC,
  parameter int unsigned SOFT_CYC   = vst_pkg::SOFT_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_line_high,
  input  wire logic       i_fb_above_up,
  input  wire logic       i_fb_above_down,
  input  wire logic       i_fb_above_reset,
  input  wire logic       i_valley_above_zero,
  input  wire logic       i_valley_above_sel,
  input  wire logic       i_current_above_fb,
  input  wire logic       i_sense_below_short,
  output logic            o_gate,
  output logic            o_line_high,
  output logic [3:0]      o_updown_count,
  output logic [3:0]      o_valley_count,
  output logic            o_restart_req
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [7:0] raw_in;
  logic [7:0] syn;
  logic       line_s, up_s, down_s, rst_s, zero_s, sel_s, cur_s, short_s;

  assign raw_in = {i_line_high, i_fb_above_up, i_fb_above_down, i_fb_above_reset,
                   i_valley_above_zero, i_valley_above_sel, i_current_above_fb,
                   i_sense_below_short};

  vst_sync #(.W(8)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (raw_in),
    .o_sync    (syn)
  );

  assign {line_s, up_s, down_s, rst_s, zero_s, sel_s, cur_s, short_s} = syn;

  function automatic logic [3:0] range_min(input logic high);
    range_min = high ? vst_pkg::HIGH_MIN : vst_pkg::LOW_MIN;
  endfunction : range_min

  function automatic logic [3:0] range_max(input logic high);
    range_max = high ? vst_pkg::HIGH_MAX : vst_pkg::LOW_MAX;
  endfunction : range_max

  // ----------------------------------------------------------------------
  // Line range selection with blanking
  // ----------------------------------------------------------------------
  logic [vst_pkg::TMR_W-1:0] line_tmr_reg;
  logic                      line_high_reg;
  logic                      start_reg;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      line_tmr_reg  <= '0;
      line_high_reg <= 1'b0;
    end else if (line_s == line_high_reg) begin
      line_tmr_reg <= '0;
    end else if (line_tmr_reg >= vst_pkg::TMR_W'(vst_pkg::LINE_BLK_CYC - 1)) begin
      line_tmr_reg  <= '0;
      line_high_reg <= line_s;
    end else begin
      line_tmr_reg <= line_tmr_reg + 1'b1;
    end
  end

  assign o_line_high = line_high_reg;

  // ----------------------------------------------------------------------
  // Update period and up/down counter
  // ----------------------------------------------------------------------
  logic [vst_pkg::TMR_W-1:0] per_tmr_reg;
  logic                      per_end;
  logic                      seen_up_reg, seen_down_reg;
  logic [3:0]                ud_reg;

  assign per_end = (per_tmr_reg == vst_pkg::TMR_W'(UPDATE_CYC - 1));

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      per_tmr_reg <= '0;
    end else if (per_end) begin
      per_tmr_reg <= '0;
    end else begin
      per_tmr_reg <= per_tmr_reg + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_up_reg   <= 1'b0;
      seen_down_reg <= 1'b0;
    end else if (per_end) begin
      seen_up_reg   <= 1'b0;
      seen_down_reg <= 1'b0;
    end else begin
      seen_up_reg   <= seen_up_reg | up_s;
      seen_down_reg <= seen_down_reg | down_s;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ud_reg    <= vst_pkg::LOW_MIN;
      start_reg <= 1'b1;
    end else if (start_reg) begin
      start_reg <= 1'b0;
      ud_reg    <= range_min(line_high_reg);
    end else if (rst_s) begin
      ud_reg <= range_min(line_high_reg);
    end else if (ud_reg < range_min(line_high_reg)) begin
      ud_reg <= range_min(line_high_reg);
    end else if (ud_reg > range_max(line_high_reg)) begin
      ud_reg <= range_max(line_high_reg);
    end else if (per_end) begin
      if (!seen_up_reg && !up_s) begin
        if (ud_reg < range_max(line_high_reg)) begin
          ud_reg <= ud_reg + 4'h1;
        end
      end else if (seen_down_reg || down_s) begin
        if (ud_reg > range_min(line_high_reg)) begin
          ud_reg <= ud_reg - 4'h1;
        end
      end
    end
  end

  assign o_updown_count = ud_reg;

  // ----------------------------------------------------------------------
  // Soft start window
  // ----------------------------------------------------------------------
  logic [vst_pkg::TMR_W-1:0] soft_tmr_reg;
  logic                      soft_act;

  assign soft_act = (soft_tmr_reg < vst_pkg::TMR_W'(SOFT_CYC));

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_tmr_reg <= '0;
    end else if (soft_act) begin
      soft_tmr_reg <= soft_tmr_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Gate state machine
  // ----------------------------------------------------------------------
  vst_pkg::vst_gate_e        st_reg;
  logic [vst_pkg::TMR_W-1:0] ph_tmr_reg;
  logic [vst_pkg::TMR_W-1:0] off_tmr_reg;
  logic [vst_pkg::TMR_W-1:0] rs_len_reg;
  logic                      zero_d_reg;
  logic                      fall;
  logic [3:0]                vc_reg;
  logic                      gate_reg;
  logic                      turn_on, turn_off;

  assign fall = zero_d_reg & ~zero_s;

  assign turn_on = (st_reg == vst_pkg::VST_OFF_WAIT) &&
                   ((vc_reg == ud_reg) ||
                    (off_tmr_reg >= vst_pkg::TMR_W'(vst_pkg::MAX_OFF_CYC - 1)));

  assign turn_off = (st_reg == vst_pkg::VST_ON) &&
                    ((cur_s && ph_tmr_reg >= vst_pkg::TMR_W'(vst_pkg::LEB_CYC)) ||
                     (ph_tmr_reg >= vst_pkg::TMR_W'(vst_pkg::MAX_ON_CYC - 1)));

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg     <= vst_pkg::VST_OFF_SUPPRESS;
      ph_tmr_reg <= '0;
      rs_len_reg <= vst_pkg::TMR_W'(vst_pkg::SOFT_RS_CYC);
      gate_reg   <= 1'b0;
    end else begin
      case (st_reg)
        vst_pkg::VST_OFF_SUPPRESS: begin
          gate_reg <= 1'b0;
          if (ph_tmr_reg >= rs_len_reg - 1'b1) begin
            st_reg     <= vst_pkg::VST_OFF_WAIT;
            ph_tmr_reg <= '0;
          end else begin
            ph_tmr_reg <= ph_tmr_reg + 1'b1;
          end
        end
        vst_pkg::VST_OFF_WAIT: begin
          if (turn_on) begin
            st_reg     <= vst_pkg::VST_ON;
            gate_reg   <= 1'b1;
            ph_tmr_reg <= '0;
          end
        end
        vst_pkg::VST_ON: begin
          if (turn_off) begin
            st_reg     <= vst_pkg::VST_OFF_SUPPRESS;
            gate_reg   <= 1'b0;
            ph_tmr_reg <= '0;
            if (soft_act) begin
              rs_len_reg <= vst_pkg::TMR_W'(vst_pkg::SOFT_RS_CYC);
            end else if (sel_s) begin
              rs_len_reg <= vst_pkg::TMR_W'(vst_pkg::SHORT_RS_CYC);
            end else begin
              rs_len_reg <= vst_pkg::TMR_W'(vst_pkg::LONG_RS_CYC);
            end
          end else begin
            ph_tmr_reg <= ph_tmr_reg + 1'b1;
          end
        end
        default: begin
          st_reg     <= vst_pkg::VST_OFF_SUPPRESS;
          gate_reg   <= 1'b0;
          ph_tmr_reg <= '0;
        end
      endcase
    end
  end

  assign o_gate = gate_reg;

  // Off-time counter
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      off_tmr_reg <= '0;
    end else if (st_reg == vst_pkg::VST_ON) begin
      off_tmr_reg <= '0;
    end else begin
      off_tmr_reg <= off_tmr_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Valley counter
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_d_reg <= 1'b0;
      vc_reg     <= 4'h0;
    end else begin
      zero_d_reg <= zero_s;
      if (turn_on) begin
        vc_reg <= 4'h0;
      end else if (st_reg == vst_pkg::VST_OFF_WAIT && fall && vc_reg != 4'hF) begin
        vc_reg <= vc_reg + 4'h1;
      end
    end
  end

  assign o_valley_count = vc_reg;

  // ----------------------------------------------------------------------
  // Sense-short detection
  // ----------------------------------------------------------------------
  logic [1:0] short_cnt_reg;
  logic       restart_reg;
  logic       sample_pt;

  assign sample_pt = (st_reg == vst_pkg::VST_ON) &&
                     (ph_tmr_reg == vst_pkg::TMR_W'(vst_pkg::SAMPLE_CYC)) && !turn_off;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      short_cnt_reg <= 2'h0;
      restart_reg   <= 1'b0;
    end else if (sample_pt) begin
      if (!short_s) begin
        short_cnt_reg <= 2'h0;
      end else if (short_cnt_reg == vst_pkg::SHORT_PULSE_LIMIT - 2'h1) begin
        short_cnt_reg <= 2'h0;
        restart_reg   <= 1'b1;
      end else begin
        short_cnt_reg <= short_cnt_reg + 2'h1;
      end
    end
  end

  assign o_restart_req = restart_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_gate_fall;
    $fell(gate_reg);
  endsequence

  property p_hold_low;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      s_gate_fall |-> !gate_reg [*8];
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("gate rose in suppression");

  property p_vc_clear;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(gate_reg) |-> vc_reg == 4'h0;
  endproperty
  a_vc_clear: assert property (p_vc_clear) else $error("valley count not cleared");

  property p_ud_range;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $past(start_reg) == 1'b0 && $stable(line_high_reg) |->
        ud_reg >= range_min(line_high_reg) && ud_reg <= range_max(line_high_reg);
  endproperty
  a_ud_range: assert property (p_ud_range) else $error("counter out of range");

  property p_reset_force;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      rst_s && !start_reg && $stable(line_high_reg) |=> ud_reg == range_min($past(line_high_reg));
  endproperty
  a_reset_force: assert property (p_reset_force) else $error("counter not forced");

  property p_leb;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(gate_reg) |-> gate_reg [*8];
  endproperty
  a_leb: assert property (p_leb) else $error("on-time below blanking");

  property p_max_on;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      gate_reg |-> ph_tmr_reg < vst_pkg::TMR_W'(vst_pkg::MAX_ON_CYC);
  endproperty
  a_max_on: assert property (p_max_on) else $error("on-time too long");

  property p_cur_off;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      st_reg == vst_pkg::VST_ON && cur_s &&
        ph_tmr_reg >= vst_pkg::TMR_W'(vst_pkg::LEB_CYC) |=> !gate_reg;
  endproperty
  a_cur_off: assert property (p_cur_off) else $error("current did not end pulse");

  property p_max_off;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      !gate_reg |-> off_tmr_reg < vst_pkg::TMR_W'(vst_pkg::MAX_OFF_CYC);
  endproperty
  a_max_off: assert property (p_max_off) else $error("off-time too long");

  property p_match_on;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      st_reg == vst_pkg::VST_OFF_WAIT && vc_reg == ud_reg |=> gate_reg;
  endproperty
  a_match_on: assert property (p_match_on) else $error("no turn-on at match");

endmodule : vst_core

// ### tb/vst_stage_model.sv
// Flyback power stage and comparator flags seen by the timing core
`timescale 1ns/1ns
module vst_stage_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_gate,
  input  wire logic [15:0] i_ramp,
  input  wire logic        i_ring_en,
  input  wire logic        i_sel,
  input  wire logic        i_short,
  output logic             o_cur_above_fb,
  output logic             o_valley_above_zero,
  output logic             o_valley_above_sel,
  output logic             o_sense_below_short
);
  int   on_cnt = 0;
  int   off_cnt = 0;
  logic on;
  // Flags move just after each rising edge; ringing period 20 cycles
  always begin
    on = (i_gate === 1'b1);
    on_cnt = on ? on_cnt + 1 : 0;
    off_cnt = on ? 0 : off_cnt + 1;
    o_cur_above_fb = on && i_ramp != 16'h0000 && on_cnt >= int'(i_ramp);
    o_sense_below_short = !on || i_short || on_cnt < 5;
    o_valley_above_zero = on || !i_ring_en || off_cnt % 20 < 10;
    o_valley_above_sel = i_sel;
    @(posedge i_sys_clk);
    #1;
  end
endmodule : vst_stage_model

// ### tb/vst_core_tb.sv
// Self-checking bench for the valley switching timing core
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %0d expected %0d", $time, g, e); end end
module vst_core_tb;
  localparam int unsigned UPD  = 200;
  localparam int unsigned SOFT = 3000;
  localparam int          SR   = vst_pkg::SHORT_RS_CYC;
  localparam int          LR   = vst_pkg::LONG_RS_CYC;
  localparam int          SS   = vst_pkg::SOFT_RS_CYC;
  logic        i_sys_clk = 1'b0;
  logic        i_arst_n  = 1'b0;
  logic        line_high = 1'b0;
  logic        fb_up     = 1'b1;
  logic        fb_down   = 1'b0;
  logic        fb_reset  = 1'b0;
  logic        ring      = 1'b1;
  logic        sel       = 1'b1;
  logic        short_en  = 1'b0;
  logic [15:0] ramp      = 16'h0028;
  logic        cur, vzero, vsel, sshort;
  logic        o_gate, o_line_high, o_restart_req;
  logic [3:0]  o_updown_count, o_valley_count, vc_prev, vc_rise;
  int          fail_count = 0;
  int          num_checks = 0;
  int          n, t_off, t_on;

  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) vc_prev <= o_valley_count;

  vst_core #(.UPDATE_CYC(UPD), .SOFT_CYC(SOFT)) u_dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_line_high(line_high),
    .i_fb_above_up(fb_up), .i_fb_above_down(fb_down), .i_fb_above_reset(fb_reset),
    .i_valley_above_zero(vzero), .i_valley_above_sel(vsel),
    .i_current_above_fb(cur), .i_sense_below_short(sshort), .o_gate(o_gate),
    .o_line_high(o_line_high), .o_updown_count(o_updown_count),
    .o_valley_count(o_valley_count), .o_restart_req(o_restart_req));

  vst_stage_model u_stage (
    .i_sys_clk(i_sys_clk), .i_gate(o_gate), .i_ramp(ramp), .i_ring_en(ring),
    .i_sel(sel), .i_short(short_en), .o_cur_above_fb(cur),
    .o_valley_above_zero(vzero), .o_valley_above_sel(vsel),
    .o_sense_below_short(sshort));

  //----------------------------------------
  // Helpers
  //----------------------------------------
  task automatic conclude;
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask : tick

  task automatic rng(input logic [31:0] v, input int lo, input int hi);
    `CHK(v >= lo && v <= hi, 1'b1)
  endtask : rng

  // Cycles the gate stays at one level, bounded
  task automatic span(input logic lvl, output int c);
    c = 0;
    while (o_gate === lvl && c < 40000) begin
      tick(1);
      c++;
    end
  endtask : span

  // One whole off period then one whole on period
  task automatic pulse;
    span(1'b0, n);
    span(1'b1, n);
    span(1'b0, t_off);
    vc_rise = vc_prev;
    span(1'b1, t_on);
  endtask : pulse

  //----------------------------------------
  // Tests
  //----------------------------------------
  initial begin
    tick(16);
    `CHK(o_gate, 1'b0)
    `CHK(o_updown_count, 4'h1)
    `CHK(o_valley_count, 4'h0)
    `CHK(o_restart_req, 1'b0)
    `CHK(o_line_high, 1'b0)
    i_arst_n = 1'b1;
    span(1'b0, t_off);
    rng(t_off, SS, SS + 35);
    `CHK(vc_prev, 4'h1)
    tick(2);
    `CHK(o_valley_count, 4'h0)
    span(1'b1, t_on);
    rng(t_on + 2, 40, 46);
    tick(SOFT);
    pulse;
    rng(t_off, SR, SR + 35);
    sel = 1'b0;
    pulse;
    rng(t_off, LR, LR + 35);
    sel = 1'b1;
    ramp = 16'h0003;
    pulse;
    rng(t_on, vst_pkg::LEB_CYC, vst_pkg::LEB_CYC + 6);
    ramp = 16'h0000;
    pulse;
    rng(t_on, vst_pkg::MAX_ON_CYC, vst_pkg::MAX_ON_CYC + 6);
    ramp = 16'h0028;
    ring = 1'b0;
    pulse;
    rng(t_off, vst_pkg::MAX_OFF_CYC - 5, vst_pkg::MAX_OFF_CYC + 5);
    ring = 1'b1;
    fb_up = 1'b0;
    tick(2000);
    `CHK(o_updown_count, 4'h8)
    pulse;
    `CHK(vc_rise, 4'h8)
    fb_up = 1'b1;
    tick(1000);
    `CHK(o_updown_count, 4'h8)
    fb_down = 1'b1;
    tick(500);
    rng(o_updown_count, 5, 6);
    tick(2000);
    `CHK(o_updown_count, 4'h1)
    fb_up = 1'b0;
    fb_down = 1'b0;
    tick(1000);
    rng(o_updown_count, 5, 7);
    fb_up = 1'b1;
    fb_down = 1'b1;
    fb_reset = 1'b1;
    tick(5);
    `CHK(o_updown_count, 4'h1)
    fb_down = 1'b0;
    fb_reset = 1'b0;
    line_high = 1'b1;
    tick(1000);
    line_high = 1'b0;
    tick(200);
    `CHK(o_line_high, 1'b0)
    line_high = 1'b1;
    tick(24000);
    `CHK(o_line_high, 1'b0)
    tick(1100);
    `CHK(o_line_high, 1'b1)
    `CHK(o_updown_count, 4'h3)
    fb_up = 1'b0;
    tick(2400);
    `CHK(o_updown_count, 4'hA)
    pulse;
    `CHK(vc_rise, 4'hA)
    fb_up = 1'b1;
    fb_down = 1'b1;
    fb_reset = 1'b1;
    tick(5);
    `CHK(o_updown_count, 4'h3)
    fb_down = 1'b0;
    fb_reset = 1'b0;
    span(1'b1, n);
    short_en = 1'b1;
    for (int i = 1; i <= 3; i++) begin
      span(1'b0, n);
      span(1'b1, n);
      tick(5);
      `CHK(o_restart_req, 1'(i == 3))
    end
    conclude();
  end

  initial begin
    #(90000 * 20);
    fail_count++;
    conclude();
  end
endmodule : vst_core_tb
